//--- logic/jtl_tx_link.sv
// Contract
// [RULE1] Narrow: one-bit multiframe-end flags, low/high byte.
// [RULE2] Wide: two-bit multiframe-end flags over four bytes.
// [RULE3] Narrow: multiframe-start flags for low/high byte.
// [RULE4] Wide: two-bit multiframe-start flags over four bytes.
// [RULE5] Narrow: frame-end flags for low/high byte.
// [RULE6] Wide: two-bit frame-end flags over four bytes.
// [RULE7] Low frame-start flag marks bytes 7:0, 23:16.
// [RULE8] High frame-start bit 0 marks bytes 15:8.
// [RULE9] Wide: high frame-start bit 1 marks 31:24.
// [RULE10] Restart request falling edge restarts CGS and ILAS.
// [RULE11] Two-bit output shows control block state.
// [RULE12] ILAS always lasts exactly four multiframes.
// [RULE13] SYSREF marks multiframe start for local timing.
// [RULE14] Converter requests synchronization through sync_n.
// [RULE15] Low sync_n gives CGS, then ILAS.
// [RULE16] Sixteen data bits per lane toward PCS.
// [RULE17] One control-character flag per octet.
// [RULE18] User supplies aligned payload, lane-width per lane.
// [RULE19] Wide variant runs at half core rate.
// [RULE20] Low reset puts block in reset state.
// [RULE21] User framer derives frame and octet clocks.
// [RULE22] User gives two octets per lane per cycle.
// [RULE23] Payload scrambler is bypassable by configuration.
// [RULE24] Insert alignment, framing and configuration characters.
// [RULE25] Controller selects payload or sequence data.
// [RULE26] User aligns frame octets to boundary flags.
// [RULE27] Upper byte carries earlier octet of pair.
// [RULE28] Boundary flags lead their data by one cycle.
// [RULE29] All link parameters sent in configuration data.
// [RULE30] Only F, K, L shape the hardware.
// [RULE31] Scrambler polynomial is 1 + x^14 + x^15.
module jtl_tx_link (
  // Clock and synchronous active-low reset.
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // AXI4-Lite register slave.
  input  wire logic [jtl_pkg::AW-1:0]           s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [jtl_pkg::AW-1:0]           s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // User framer side.
  input  wire logic [8*jtl_pkg::LANES*jtl_pkg::OCT-1:0] user_data_in,
  output jtl_pkg::jtl_flags_s                   boundary_flags,
  // Link control from the converter and system.
  input  wire logic                             sync_n,
  input  wire logic                             sysref,
  input  wire logic                             restart_request_low,
  input  wire logic [7:0]                       ila_multiframe_count,
  output jtl_pkg::jtl_state_e                   link_state,
  // Octets and control flags toward the PCS.
  output logic [8*jtl_pkg::LANES*jtl_pkg::OCT-1:0] tx_data,
  output logic [jtl_pkg::LANES*jtl_pkg::OCT-1:0] tx_k
);

  // Position of the octet that starts the next cycle's lane word.
  logic [jtl_pkg::CW-1:0] lead;
  // Position of the octet that starts this cycle's lane word.
  logic [jtl_pkg::CW-1:0] cur;
  // Next value of the lead position.
  logic [jtl_pkg::CW-1:0] next_lead;
  // Next value of the boundary flags.
  jtl_pkg::jtl_flags_s    next_flags;
  // Next control block state.
  jtl_pkg::jtl_state_e    next_state;
  // Multiframe counter within the alignment sequence.
  logic [1:0]             mf_cnt;
  // Restart request seen in the previous cycle.
  logic                   restart_q;
  // Falling edge of the restart request.
  logic                   restart_fall;
  // This cycle's lane word holds the multiframe's last octet.
  logic                   mf_end_now;
  // Control register and scrambler enable taken from it.
  logic [31:0]            ctrl;
  logic                   scr_en;
  // Write address and data captured, awaiting the other half.
  logic                   aw_full;
  logic                   w_full;
  logic [jtl_pkg::AW-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;

  assign restart_fall = restart_q & ~restart_request_low;
  assign mf_end_now   = (int'(cur) + jtl_pkg::OCT) >= jtl_pkg::MFO;
  assign scr_en       = ctrl[jtl_pkg::CTRL_SCR];
  assign wr_fire      = aw_full & w_full & ~s_axi_bvalid;

  // Octet i of a lane word in time order sits at this bit offset; the
  // upper byte of each 16-bit group is sent first.
  function automatic int oct_off(input int i);
    oct_off = (i / 2) * 16 + (((i % 2) == 0) ? 8 : 0); // [RULE27]
  endfunction

  // Link configuration octets 0 to 12, before the checksum.
  function automatic logic [7:0] cfg_field(input int idx, input int ln,
                                           input logic scr);
    case (idx)
      0:       cfg_field = jtl_pkg::DEV_ID;
      1:       cfg_field = {4'h0, jtl_pkg::BANK_ID};
      2:       cfg_field = {3'h0, 5'(ln)};
      3:       cfg_field = {scr, 2'h0, 5'(jtl_pkg::LANES - 1)};
      4:       cfg_field = 8'(jtl_pkg::F - 1);
      5:       cfg_field = {3'h0, 5'(jtl_pkg::K - 1)};
      6:       cfg_field = 8'(jtl_pkg::M - 1);
      7:       cfg_field = {2'(jtl_pkg::CS), 1'b0, 5'(jtl_pkg::N - 1)};
      8:       cfg_field = {3'(jtl_pkg::SUBCLASS), 5'(jtl_pkg::NP - 1)};
      9:       cfg_field = {3'(jtl_pkg::JESDV), 5'(jtl_pkg::S - 1)};
      10:      cfg_field = {1'(jtl_pkg::HD), 2'h0, 5'(jtl_pkg::CF)};
      default: cfg_field = 8'h00;
    endcase
  endfunction

  // Configuration octet at a given index, the last one a checksum.
  function automatic logic [7:0] cfg_octet(input int idx, input int ln,
                                           input logic scr);
    logic [7:0] sum;
    sum = 8'h00;
    if (idx == 13) begin
      for (int j = 0; j < 13; j++) begin
        sum = sum + cfg_field(j, ln, scr);
      end
      cfg_octet = sum;
    end else begin
      cfg_octet = cfg_field(idx, ln, scr); // [RULE29] [RULE30]
    end
  endfunction

  // Self-synchronous scrambler over one lane word, octets in time order,
  // most significant bit first; returns {new history, scrambled word}.
  function automatic logic [jtl_pkg::LANE_DATA_WIDTH+14:0] scramble(
      input logic [jtl_pkg::LANE_DATA_WIDTH-1:0] d, input logic [14:0] hist);
    logic [14:0]                          h;
    logic [jtl_pkg::LANE_DATA_WIDTH-1:0]  o;
    logic                                 b;
    h = hist;
    o = d;
    for (int i = 0; i < jtl_pkg::OCT; i++) begin
      for (int k = 7; k >= 0; k--) begin
        b = d[oct_off(i) + k] ^ h[13] ^ h[14]; // [RULE31]
        o[oct_off(i) + k] = b;
        h = {h[13:0], b};
      end
    end
    scramble = {h, o};
  endfunction

  // The lead position advances by one lane word per cycle; SYSREF moves
  // the multiframe start to the next cycle's first octet.
  always_comb begin
    int t;
    t = int'(lead) + jtl_pkg::OCT; // [RULE19] [RULE22]
    if (t >= jtl_pkg::MFO) begin
      t = t - jtl_pkg::MFO;
    end
    if (sysref) begin
      next_lead = jtl_pkg::CW'(jtl_pkg::OCT); // [RULE13]
    end else begin
      next_lead = jtl_pkg::CW'(t);
    end
  end

  // Boundary flags describing the word that follows them by one cycle.
  always_comb begin
    int p;
    int g;
    p = 0;
    g = 0;
    next_flags = '0;
    for (int i = 0; i < jtl_pkg::OCT; i++) begin
      // Octet i of the word the user presents one cycle after these flags
      // show; next_lead already holds any SYSREF realignment.
      p = int'(next_lead) + i;
      if (p >= jtl_pkg::MFO) begin
        p = p - jtl_pkg::MFO;
      end
      g = i / 2;
      if ((i % 2) == 0) begin
        // High byte of group g: bits 15:8 or 31:24.
        next_flags.multiframe_last_high_flag[g] =
          (p == jtl_pkg::MFO - 1); // [RULE1] [RULE2]
        next_flags.multiframe_first_high_flag[g] = (p == 0); // [RULE3] [RULE4]
        next_flags.frame_last_high_flag[g] =
          ((p % jtl_pkg::F) == jtl_pkg::F - 1); // [RULE5] [RULE6]
        next_flags.frame_first_high_flag[g] =
          ((p % jtl_pkg::F) == 0); // [RULE8] [RULE9]
      end else begin
        // Low byte of group g: bits 7:0 or 23:16.
        next_flags.multiframe_last_low_flag[g] =
          (p == jtl_pkg::MFO - 1); // [RULE1] [RULE2]
        next_flags.multiframe_first_low_flag[g] = (p == 0); // [RULE3] [RULE4]
        next_flags.frame_last_low_flag[g] =
          ((p % jtl_pkg::F) == jtl_pkg::F - 1); // [RULE5] [RULE6]
        next_flags.frame_first_low_flag[g] =
          ((p % jtl_pkg::F) == 0); // [RULE7]
      end
    end
  end

  // Position counters and flags; flags are registered with the lead so
  // that they sit one cycle ahead of the word they describe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lead           <= jtl_pkg::CW'(jtl_pkg::OCT); // [RULE20]
      cur            <= '0;
      boundary_flags <= '0;
    end else begin
      lead           <= next_lead;
      cur            <= sysref ? '0 : lead;
      boundary_flags <= next_flags; // [RULE28] [RULE26]
    end
  end

  // Control block: CGS until sync_n rises, wait for a multiframe
  // boundary, four ILAS multiframes, then payload.
  always_comb begin
    next_state = link_state;
    case (link_state)
      jtl_pkg::ST_CGS: begin
        if (sync_n) begin
          next_state = jtl_pkg::ST_WAIT;
        end
      end
      jtl_pkg::ST_WAIT: begin
        if (next_lead == jtl_pkg::CW'(jtl_pkg::OCT) || sysref) begin
          next_state = jtl_pkg::ST_ILAS;
        end
      end
      jtl_pkg::ST_ILAS: begin
        if (mf_end_now && mf_cnt == 2'(jtl_pkg::ILAS_MF - 1)) begin
          next_state = jtl_pkg::ST_DATA; // [RULE12]
        end
      end
      jtl_pkg::ST_DATA: next_state = jtl_pkg::ST_DATA;
      default:          next_state = jtl_pkg::ST_CGS;
    endcase
    if (!sync_n || restart_fall) begin
      next_state = jtl_pkg::ST_CGS; // [RULE10] [RULE15]
    end
  end

  // State register, restart edge history and ILAS multiframe count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_state <= jtl_pkg::ST_CGS; // [RULE20]
      restart_q  <= 1'b1;
      mf_cnt     <= 2'h0;
    end else begin
      link_state <= next_state; // [RULE11]
      restart_q  <= restart_request_low;
      if (link_state != jtl_pkg::ST_ILAS) begin
        mf_cnt <= 2'h0;
      end else if (mf_end_now) begin
        mf_cnt <= mf_cnt + 2'h1;
      end
    end
  end

  // Per-lane scrambler and output selection toward the PCS.
  for (genvar ln = 0; ln < jtl_pkg::LANES; ln++) begin : g_lane
    logic [14:0]                          hist;
    logic [jtl_pkg::LANE_DATA_WIDTH+14:0] scr_out;
    logic [jtl_pkg::LANE_DATA_WIDTH-1:0]  raw;
    logic [jtl_pkg::LANE_DATA_WIDTH-1:0]  next_data;
    logic [jtl_pkg::OCT-1:0]              next_k;
    logic [jtl_pkg::LANE_DATA_WIDTH-1:0]  lane_data;
    logic [jtl_pkg::OCT-1:0]              lane_k;

    assign raw     = user_data_in[ln*jtl_pkg::LANE_DATA_WIDTH +:
                                  jtl_pkg::LANE_DATA_WIDTH]; // [RULE18]
    assign scr_out = scramble(raw, hist);

    // Picks one octet and its k flag per position from the state.
    always_comb begin
      int         p;
      logic [7:0] d;
      p = 0;
      d = 8'h00;
      next_data = '0;
      next_k    = '0;
      for (int i = 0; i < jtl_pkg::OCT; i++) begin
        p = int'(cur) + i;
        d = raw[oct_off(i) +: 8];
        case (link_state)
          jtl_pkg::ST_ILAS: begin
            if (p == 0) begin
              next_data[oct_off(i) +: 8] = jtl_pkg::CH_R; // [RULE24]
              next_k[i] = 1'b1;
            end else if (p == jtl_pkg::MFO - 1) begin
              next_data[oct_off(i) +: 8] = jtl_pkg::CH_A;
              next_k[i] = 1'b1;
            end else if (mf_cnt == 2'h1 && p == 1) begin
              next_data[oct_off(i) +: 8] = jtl_pkg::CH_Q;
              next_k[i] = 1'b1;
            end else if (mf_cnt == 2'h1 && p >= 2 && p < 16) begin
              next_data[oct_off(i) +: 8] = cfg_octet(p - 2, ln, scr_en);
            end else begin
              next_data[oct_off(i) +: 8] = 8'(p);
            end
          end
          jtl_pkg::ST_DATA: begin
            if (scr_en) begin
              next_data[oct_off(i) +: 8] =
                scr_out[oct_off(i) +: 8]; // [RULE23]
            end else begin
              // Unscrambled boundary octets that equal A or F go out as
              // control characters so the receiver can check alignment.
              next_data[oct_off(i) +: 8] = d; // [RULE25]
              next_k[i] = (p == jtl_pkg::MFO - 1 && d == jtl_pkg::CH_A) ||
                          ((p % jtl_pkg::F) == jtl_pkg::F - 1 &&
                           d == jtl_pkg::CH_F); // [RULE24]
            end
          end
          default: begin
            next_data[oct_off(i) +: 8] = jtl_pkg::CH_K; // [RULE14]
            next_k[i] = 1'b1;
          end
        endcase
      end
    end

    // Registers the lane word; history advances only on payload.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hist      <= '0;
        lane_data <= '0;
        lane_k    <= '0;
      end else begin
        if (link_state == jtl_pkg::ST_DATA) begin
          hist <= scr_out[jtl_pkg::LANE_DATA_WIDTH +: 15];
        end
        lane_data <= next_data; // [RULE16]
        lane_k    <= next_k; // [RULE17]
      end
    end

    assign tx_data[ln*jtl_pkg::LANE_DATA_WIDTH +:
                   jtl_pkg::LANE_DATA_WIDTH]        = lane_data;
    assign tx_k[ln*jtl_pkg::OCT +: jtl_pkg::OCT]    = lane_k;
  end

  // AXI4-Lite write channel: address and data taken in either order,
  // response once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= jtl_pkg::RESP_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_full       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_full       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == jtl_pkg::REG_CTRL ||
                         aw_addr == jtl_pkg::REG_STATUS) ?
                        jtl_pkg::RESP_OKAY : jtl_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register; only byte lane 0 holds writable bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= jtl_pkg::CTRL_RESET;
    end else if (wr_fire && aw_addr == jtl_pkg::REG_CTRL && w_strb[0]) begin
      ctrl <= {31'h0000_0000, w_data[jtl_pkg::CTRL_SCR]};
    end
  end

  // AXI4-Lite read channel: one read at a time, status shows live state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= jtl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= jtl_pkg::RESP_OKAY;
        if (s_axi_araddr == jtl_pkg::REG_CTRL) begin
          s_axi_rdata <= ctrl;
        end else if (s_axi_araddr == jtl_pkg::REG_STATUS) begin
          s_axi_rdata <= {16'h0000, ila_multiframe_count, 3'h0, sync_n,
                          mf_cnt, link_state};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= jtl_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Cycles spent in the alignment sequence, for checking its length.
  logic [7:0] ilas_cyc;
  always_ff @(posedge aclk) begin
    if (!aresetn || link_state != jtl_pkg::ST_ILAS) begin
      ilas_cyc <= 8'h00;
    end else begin
      ilas_cyc <= ilas_cyc + 8'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Waiting state meets a multiframe boundary, then ILAS starts at 0.
  sequence s_boundary_wait;
    link_state == jtl_pkg::ST_WAIT && sync_n && restart_q &&
    restart_request_low && next_lead == jtl_pkg::CW'(jtl_pkg::OCT);
  endsequence
  sequence s_ilas_start;
    link_state == jtl_pkg::ST_ILAS && cur == '0;
  endsequence

  a_ilas_entry: assert property (s_boundary_wait |=> s_ilas_start) // [RULE15]
    else $error("ILAS did not start at a multiframe boundary");
  a_ilas_length: assert property ( // [RULE12]
    link_state == jtl_pkg::ST_ILAS && next_state == jtl_pkg::ST_DATA
    |-> int'(ilas_cyc) == jtl_pkg::ILAS_CYC - 1)
    else $error("ILAS length is not four multiframes");
  a_restart_cgs: assert property ( // [RULE10]
    $fell(restart_request_low) |=> link_state == jtl_pkg::ST_CGS)
    else $error("restart request did not return to CGS");
  a_sync_cgs: assert property ( // [RULE15]
    !sync_n |=> link_state == jtl_pkg::ST_CGS ##1 (&tx_k))
    else $error("sync request did not produce CGS characters");
  a_mf_first: assert property ( // [RULE3]
    boundary_flags.multiframe_first_high_flag[0] |=> cur == '0)
    else $error("multiframe start flag not one cycle ahead");
  a_mf_last: assert property ( // [RULE1]
    boundary_flags.multiframe_last_low_flag[0]
    |=> int'(cur) + 1 == jtl_pkg::MFO - 1)
    else $error("multiframe end flag misplaced");
  a_frame_first: assert property ( // [RULE8]
    boundary_flags.frame_first_high_flag[0]
    |=> (int'(cur) % jtl_pkg::F) == 0)
    else $error("frame start flag misplaced");
  a_frame_last: assert property ( // [RULE5]
    boundary_flags.frame_last_low_flag[0]
    |=> ((int'(cur) + 1) % jtl_pkg::F) == jtl_pkg::F - 1)
    else $error("frame end flag misplaced");
  a_sysref_align: assert property ( // [RULE13]
    sysref |=> cur == '0 ##0 boundary_flags.frame_first_high_flag[0] ==
    (jtl_pkg::OCT % jtl_pkg::F == 0))
    else $error("sysref did not realign the multiframe");
  a_write_resp: assert property (
    wr_fire |=> s_axi_bvalid && !aw_full && !w_full)
    else $error("write response not raised after both halves");
endmodule

//--- shared/jtl_pkg.sv
// Shared constants, types and register map of the transmit link layer.
package jtl_pkg;
  // Lane count and datapath variant; WIDE selects 32-bit lane words.
  localparam int LANES = 2;
  localparam int WIDE  = 0;
  // Boundary flag width: one bit per 16-bit group of a lane word.
  localparam int W     = (WIDE != 0) ? 2 : 1;
  // Octets per lane per core clock cycle, and lane word width.
  localparam int OCT   = 2 * W;
  localparam int LANE_DATA_WIDTH = 8 * OCT;
  // Structural link parameters: octets per frame, frames per multiframe.
  localparam int F     = 2;
  localparam int K     = 16;
  // Octets per multiframe and the width of a position counter.
  localparam int MFO   = F * K;
  localparam int CW    = $clog2(MFO);
  // Initial lane alignment length in multiframes and in core cycles.
  localparam int ILAS_MF  = 4;
  localparam int ILAS_CYC = ILAS_MF * MFO / OCT;
  // Configuration values that are only transmitted, never structural.
  localparam int M     = 2;
  localparam int N     = 12;
  localparam int NP    = 12;
  localparam int S     = 1;
  localparam int CS    = 0;
  localparam int CF    = 0;
  localparam int HD    = 0;
  localparam int SUBCLASS = 1;
  localparam int JESDV = 1;
  // Device and bank identifiers; these values are arbitrary.
  localparam logic [7:0] DEV_ID  = 8'h5A;
  localparam logic [3:0] BANK_ID = 4'h3;
  // Control characters sent with the k flag set.
  localparam logic [7:0] CH_R = 8'h1C;
  localparam logic [7:0] CH_A = 8'h7C;
  localparam logic [7:0] CH_Q = 8'h9C;
  localparam logic [7:0] CH_K = 8'hBC;
  localparam logic [7:0] CH_F = 8'hFC;
  // Register map on the AXI4-Lite slave.
  localparam int          AW         = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam int          CTRL_SCR   = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Transmit control block states.
  typedef enum logic [1:0] {
    ST_CGS  = 2'b00,
    ST_WAIT = 2'b01,
    ST_ILAS = 2'b10,
    ST_DATA = 2'b11
  } jtl_state_e;
  // Frame and multiframe boundary flags toward the user framer.
  typedef struct packed {
    logic [W-1:0] multiframe_last_low_flag;
    logic [W-1:0] multiframe_last_high_flag;
    logic [W-1:0] multiframe_first_low_flag;
    logic [W-1:0] multiframe_first_high_flag;
    logic [W-1:0] frame_last_low_flag;
    logic [W-1:0] frame_last_high_flag;
    logic [W-1:0] frame_first_low_flag;
    logic [W-1:0] frame_first_high_flag;
  } jtl_flags_s;
endpackage

//--- test/jtl_conv_model.sv
module jtl_conv_model (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Bench asks for a new alignment while high.
  input  wire logic want_sync,
  // Lines toward the link layer.
  output logic      sync_n,
  output logic      sysref
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lmfc = 4'h0; // Local multiframe clock, 16 cycles long.
  initial sync_n = 1'h0;
  initial sysref = 1'h0;
  // Ask for alignment in reset or on demand; mark each multiframe start.
  always @(posedge aclk) begin
    sync_n <= aresetn & ~want_sync;
    lmfc <= aresetn ? lmfc + 4'h1 : 4'h0;
    // The pulse sits in the last word of each multiframe as the link layer
    // counts it from reset, so realignment keeps its phase.
    sysref <= aresetn & (lmfc == 4'hE);
  end
endmodule

//--- test/jtl_tx_link_tb.sv
module jtl_tx_link_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Bench signals; names match the ports they drive or watch.
  logic aclk = 0, aresetn = 0, want_sync = 1, restart_request_low = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_n, sysref;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ila_multiframe_count = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, user_data_in = 0, tx_data, mc;
  logic [31:0] prv = 0, got, x; // Descrambler history and result.
  logic scr = 0; // Lanes carry scrambled payload.
  logic [3:0] s_axi_wstrb = 4'hF, tx_k;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] exp_q[$]; // Words due on the lanes, oldest first.
  jtl_pkg::jtl_flags_s boundary_flags;
  jtl_pkg::jtl_state_e link_state;
  int fails = 0, samples_checked = 0, cyc = 0, n = 0, seed = 10987;
  // Core clock, 50 ns period.
  initial forever #25 aclk = ~aclk;
  jtl_tx_link uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .user_data_in, .boundary_flags, .sync_n, .sysref, .restart_request_low,
    .ila_multiframe_count, .link_state, .tx_data, .tx_k);
  jtl_conv_model conv (.aclk, .aresetn, .want_sync, .sync_n, .sysref);
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register write; each channel drops once taken, bready is raised with them and held until bvalid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(jtl_pkg::RESP_OKAY), 32'(s_axi_bresp));
  endtask
  // Register read; masked data and response taken where rvalid is seen.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", 32'(r), 32'(s_axi_rresp));
  endtask
  // Drive one payload word, note it, tally the multiframe flags and check the frame flags.
  task automatic send(input logic [31:0] v);
    @(posedge aclk);
    user_data_in <= v;
    @(negedge aclk);
    exp_q.push_back(v);
    for (int i = 0; i < 4; i++) mc[8*i +: 8] += 8'(boundary_flags[4+i]);
    chk("frame flags", 32'h9,
        32'(boundary_flags[3:0]));
  endtask
  // Look for a state within six cycles.
  task automatic see(input jtl_pkg::jtl_state_e s);
    logic hit = 1'h0;
    repeat (6) begin
      @(posedge aclk);
      #1;
      hit |= (link_state === s);
    end
    chk("state", 32'h1, 32'(hit));
  endtask
  // Watcher: a noted word shows on the lanes one edge after it was driven.
  // Scrambled lanes are undone by 1 + x^14 + x^15, the word before giving
  // the history.
  always begin
    @(posedge aclk);
    #1;
    got = tx_data;
    for (int l = 0; l < 32; l += 16) begin
      x = {prv[l +: 16], tx_data[l +: 16]};
      if (scr) got[l +: 16] = x[15:0] ^ x[29:14] ^ x[30:15];
    end
    prv = tx_data;
    if (exp_q.size() > 0) begin
      chk("lane data", exp_q.pop_front(), got);
      chk("lane k", 32'h0, 32'(tx_k));
    end
  end
  // Hang guard.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end
  initial begin
    ila_multiframe_count = 8'($random(seed));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1;
    chk("reset", 32'(jtl_pkg::ST_CGS), 32'(link_state));
    chk("cgs data", 32'hBCBC_BCBC, tx_data);
    chk("cgs k", 32'hF, 32'(tx_k));
    $display("test reset done");
    @(posedge aclk);
    want_sync <= 1'h0;
    while (link_state !== jtl_pkg::ST_DATA) begin
      @(posedge aclk);
      #1;
      if (link_state === jtl_pkg::ST_ILAS) n++;
    end
    chk("ilas", 32'(4 * jtl_pkg::F * jtl_pkg::K / 2), 32'(n));
    $display("test bring-up done");
    mc = 32'h0;
    repeat (64) send($random(seed) | 32'h0101_0101);
    chk("mf flags", 32'h0400_0004, mc);
    $display("test data done");
    wr(jtl_pkg::REG_CTRL, 32'h1);
    rd(jtl_pkg::REG_CTRL, 32'h1, 32'h1, jtl_pkg::RESP_OKAY);
    rd(jtl_pkg::REG_STATUS, 32'hFF03, {16'h0, ila_multiframe_count, 8'h3},
       jtl_pkg::RESP_OKAY);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0, jtl_pkg::RESP_SLVERR);
    $display("test registers done");
    scr = 1'h1;
    repeat (8) send($random(seed));
    $display("test scrambler done");
    @(posedge aclk);
    restart_request_low <= 1'h0;
    see(jtl_pkg::ST_CGS);
    @(posedge aclk);
    want_sync <= 1'h1;
    see(jtl_pkg::ST_CGS);
    $display("test restart done");
    conclude;
  end
endmodule
